// ---- rtl/tmr_map.svh ----
// register offsets, field positions, reset values and timing masks of the pulse timer
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register byte offsets, one aligned word each
`define TMR_OFF_CTRL1 8'h00
`define TMR_OFF_CTRL2 8'h04
`define TMR_OFF_STATUS 8'h08
`define TMR_OFF_CAP1_HI 8'h0C
`define TMR_OFF_CAP1_LO 8'h10
`define TMR_OFF_CAP2_HI 8'h14
`define TMR_OFF_CAP2_LO 8'h18
`define TMR_OFF_CMP1_HI 8'h1C
`define TMR_OFF_CMP1_LO 8'h20
`define TMR_OFF_CMP2_HI 8'h24
`define TMR_OFF_CMP2_LO 8'h28
`define TMR_OFF_CNT_HI 8'h2C
`define TMR_OFF_CNT_LO 8'h30

// timer_control_one fields
`define TMR_C1_CAP_IRQ_EN 7
`define TMR_C1_CMP_IRQ_EN 6
`define TMR_C1_TRIG_EDGE_ONE 2
`define TMR_C1_LEVEL_TWO 1
`define TMR_C1_LEVEL_ONE 0

// timer_control_two fields
`define TMR_C2_OUT1_EN 7
`define TMR_C2_OUT2_EN 6
`define TMR_C2_SINGLE_SHOT 5
`define TMR_C2_PWM 4
`define TMR_C2_CLK_HI 3
`define TMR_C2_CLK_LO 2
`define TMR_C2_TRIG_EDGE_TWO 1
`define TMR_C2_EXT_EDGE 0

// timer_status_reg fields
`define TMR_ST_CAP_FLAG_ONE 7
`define TMR_ST_CMP_FLAG_ONE 6
`define TMR_ST_CAP_FLAG_TWO 4
`define TMR_ST_CMP_FLAG_TWO 3

// reset values
`define TMR_RST_CTRL1 8'h00
`define TMR_RST_CTRL2 8'h00
`define TMR_RST_CNT 16'h0000
`define TMR_RST_CMP 16'hFFFF

// counter reload on trigger or end of period
`define TMR_RELOAD 16'hFFFC

// clock select codes and prescaler masks (tick when all mask bits set)
`define TMR_CLK_DIV4 2'b00
`define TMR_CLK_DIV2 2'b01
`define TMR_CLK_DIV8 2'b10
`define TMR_CLK_EXT 2'b11
`define TMR_MASK_DIV2 3'h1
`define TMR_MASK_DIV4 3'h3
`define TMR_MASK_DIV8 3'h7

`endif

// ---- rtl/tmr_pkg.sv ----
// types of the pulse timer: bus carriers, mode code and the state record
package tmr_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tmr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmr_apb_rsp_t;

  typedef enum logic [2:0] {
    TMR_MODE_CMP = 3'b001,
    TMR_MODE_ONE = 3'b010,
    TMR_MODE_PWM = 3'b100
  } tmr_mode_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] cnt;
    logic [2:0] presc;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] sh1;
    logic [15:0] sh2;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic lock1;
    logic lock2;
    logic cf1;
    logic cf2;
    logic mf1;
    logic mf2;
    logic [3:0] arm;
    logic [2:0] s_in1;
    logic [2:0] s_in2;
    logic [2:0] s_ext;
    logic out1;
    logic out2;
    logic [31:0] rdata;
  } tmr_state_t;

endpackage : tmr_pkg

// ---- rtl/tmr_pulse_timer.sv ----
// 16-bit timer with one-pulse and pwm modes behind an apb register slave
// Operation
// - trigger edge captures, reloads, drives during-level, flags
// - match on value one drives after-level
// - capture flag one raises irq when enabled
// - flag clears: status read, then low byte
// - single shot never sets compare flag one
// - both selects set means pwm only
// - equal levels keep output one constant in single shot and pwm
// - single shot: input one resets and captures
// - pwm loads shadows at period end
// - high byte write locks until low byte
// - pwm compare always enabled
// - pwm matches drive levels, reload, flag
// - pwm sets no compare flags
// - pwm period end sets capture flag one
// - bit 7 routes output one to pin
// - bit 6 routes output two to pin
// - bit 5 selects single shot pulse
// - bit 4 selects cyclic pwm output
// - clock select: div4, div2, div8, external
// - no external pin: external select stops
// - bit 1 picks capture two edge
// - bit 0 picks external clock edge
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_pulse_timer import tmr_pkg::*; #(
  // clear on a part without the external clock pin
  parameter bit HAS_EXT_PIN = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tmr_apb_req_t apb_req,
  output tmr_apb_rsp_t apb_rsp,
  // trigger and clock pins
  input wire logic capture_in_pin_one,
  input wire logic capture_in_pin_two,
  input wire logic ext_timer_clock_pin,
  // waveform pins
  output logic compare_out_pin_one_o,
  output logic compare_out_pin_one_oe,
  output logic compare_out_pin_two_o,
  output logic compare_out_pin_two_oe,
  // interrupt request toward the core
  output logic timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state and decode

  tmr_state_t s;
  tmr_state_t next_s;

  tmr_mode_t mode;
  logic [1:0] clock_select;
  logic level_after_match_one;
  logic level_after_match_two;
  logic trigger_edge_one;
  logic trigger_edge_two;
  logic ext_clock_edge_sel;
  logic single_shot_select;
  logic pwm_select;
  logic capture_irq_enable;
  logic compare_irq_enable;
  logic [2:0] presc_mask;
  logic tick;
  logic edge_one;
  logic edge_two;
  logic ext_edge;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] read_value;
  logic capture_request;
  logic compare_request;

  assign level_after_match_one = s.ctrl1[`TMR_C1_LEVEL_ONE];
  assign level_after_match_two = s.ctrl1[`TMR_C1_LEVEL_TWO];
  assign trigger_edge_one = s.ctrl1[`TMR_C1_TRIG_EDGE_ONE];
  assign capture_irq_enable = s.ctrl1[`TMR_C1_CAP_IRQ_EN];
  assign compare_irq_enable = s.ctrl1[`TMR_C1_CMP_IRQ_EN];
  assign single_shot_select = s.ctrl2[`TMR_C2_SINGLE_SHOT];
  assign pwm_select = s.ctrl2[`TMR_C2_PWM];
  assign clock_select = s.ctrl2[`TMR_C2_CLK_HI:`TMR_C2_CLK_LO];
  assign trigger_edge_two = s.ctrl2[`TMR_C2_TRIG_EDGE_TWO];
  assign ext_clock_edge_sel = s.ctrl2[`TMR_C2_EXT_EDGE];

  // pwm wins over single shot when both are set
  always_comb begin
    if (pwm_select) begin
      mode = TMR_MODE_PWM;
    end else if (single_shot_select) begin
      mode = TMR_MODE_ONE;
    end else begin
      mode = TMR_MODE_CMP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edges on synchronised pins (stage 1 vs stage 2, never stage 0)
  // a pin change is acted on at the third clock edge

  assign edge_one = trigger_edge_one ? (s.s_in1[1] & ~s.s_in1[2]) : (~s.s_in1[1] & s.s_in1[2]);
  assign edge_two = trigger_edge_two ? (s.s_in2[1] & ~s.s_in2[2]) : (~s.s_in2[1] & s.s_in2[2]);
  assign ext_edge = ext_clock_edge_sel ? (s.s_ext[1] & ~s.s_ext[2]) : (~s.s_ext[1] & s.s_ext[2]);

  ////////////////////////////////////////////////////////////////////////////
  // timer clock select
  // free prescaler: the first tick after a select change may come early

  always_comb begin
    presc_mask = `TMR_MASK_DIV4;
    tick = 1'b0;
    unique case (clock_select)
      `TMR_CLK_DIV4: begin
        presc_mask = `TMR_MASK_DIV4;
        tick = (s.presc & presc_mask) == presc_mask;
      end
      `TMR_CLK_DIV2: begin
        presc_mask = `TMR_MASK_DIV2;
        tick = (s.presc & presc_mask) == presc_mask;
      end
      `TMR_CLK_DIV8: begin
        presc_mask = `TMR_MASK_DIV8;
        tick = (s.presc & presc_mask) == presc_mask;
      end
      `TMR_CLK_EXT: begin
        // a part without the pin simply never ticks
        tick = HAS_EXT_PIN & ext_edge;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode and read mux
  // counter halves are read live, so a tick between hi and lo can tear

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;

  always_comb begin
    mapped = 1'b1;
    read_value = 32'h0000_0000;
    unique case (apb_req.paddr)
      `TMR_OFF_CTRL1: read_value[7:0] = s.ctrl1;
      `TMR_OFF_CTRL2: read_value[7:0] = s.ctrl2;
      `TMR_OFF_STATUS: begin
        read_value[`TMR_ST_CAP_FLAG_ONE] = s.cf1;
        read_value[`TMR_ST_CMP_FLAG_ONE] = s.mf1;
        read_value[`TMR_ST_CAP_FLAG_TWO] = s.cf2;
        read_value[`TMR_ST_CMP_FLAG_TWO] = s.mf2;
      end
      `TMR_OFF_CAP1_HI: read_value[7:0] = s.cap1[15:8];
      `TMR_OFF_CAP1_LO: read_value[7:0] = s.cap1[7:0];
      `TMR_OFF_CAP2_HI: read_value[7:0] = s.cap2[15:8];
      `TMR_OFF_CAP2_LO: read_value[7:0] = s.cap2[7:0];
      `TMR_OFF_CMP1_HI: read_value[7:0] = s.cmp1[15:8];
      `TMR_OFF_CMP1_LO: read_value[7:0] = s.cmp1[7:0];
      `TMR_OFF_CMP2_HI: read_value[7:0] = s.cmp2[15:8];
      `TMR_OFF_CMP2_LO: read_value[7:0] = s.cmp2[7:0];
      `TMR_OFF_CNT_HI: read_value[7:0] = s.cnt[15:8];
      `TMR_OFF_CNT_LO: read_value[7:0] = s.cnt[7:0];
      default: mapped = 1'b0;
    endcase
  end

  // read data is latched in the setup cycle, so no wait state is needed
  assign apb_rsp.prdata = s.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;

    // two-flop synchronisers plus a history stage for edge detection
    next_s.s_in1 = {s.s_in1[1:0], capture_in_pin_one};
    next_s.s_in2 = {s.s_in2[1:0], capture_in_pin_two};
    next_s.s_ext = {s.s_ext[1:0], ext_timer_clock_pin};
    next_s.presc = s.presc + 3'h1;

    if (setup) begin
      next_s.rdata = read_value;
    end

    // bus side first, so hardware sets below win over a clear
    if (access && mapped) begin
      if (apb_req.paddr == `TMR_OFF_STATUS && !apb_req.pwrite) begin
        next_s.arm = {s.mf2, s.cf2, s.mf1, s.cf1};
      end
      if (apb_req.paddr == `TMR_OFF_CAP1_LO && s.arm[0]) begin
        next_s.cf1 = 1'b0;
        next_s.arm[0] = 1'b0;
      end
      if (apb_req.paddr == `TMR_OFF_CMP1_LO && s.arm[1]) begin
        next_s.mf1 = 1'b0;
        next_s.arm[1] = 1'b0;
      end
      if (apb_req.paddr == `TMR_OFF_CAP2_LO && s.arm[2]) begin
        next_s.cf2 = 1'b0;
        next_s.arm[2] = 1'b0;
      end
      if (apb_req.paddr == `TMR_OFF_CMP2_LO && s.arm[3]) begin
        next_s.mf2 = 1'b0;
        next_s.arm[3] = 1'b0;
      end
      if (apb_req.pwrite) begin
        unique case (apb_req.paddr)
          `TMR_OFF_CTRL1: next_s.ctrl1 = apb_req.pwdata[7:0];
          `TMR_OFF_CTRL2: next_s.ctrl2 = apb_req.pwdata[7:0];
          // a high byte alone keeps the shadow on its old value
          `TMR_OFF_CMP1_HI: begin
            next_s.cmp1[15:8] = apb_req.pwdata[7:0];
            next_s.lock1 = 1'b1;
          end
          `TMR_OFF_CMP1_LO: begin
            next_s.cmp1[7:0] = apb_req.pwdata[7:0];
            next_s.lock1 = 1'b0;
          end
          `TMR_OFF_CMP2_HI: begin
            next_s.cmp2[15:8] = apb_req.pwdata[7:0];
            next_s.lock2 = 1'b1;
          end
          `TMR_OFF_CMP2_LO: begin
            next_s.cmp2[7:0] = apb_req.pwdata[7:0];
            next_s.lock2 = 1'b0;
          end
          default: begin
            // read-only registers ignore writes
          end
        endcase
      end
    end

    // outside pwm the shadows take the compare values each cycle unless locked
    if (mode != TMR_MODE_PWM) begin
      if (!s.lock1) begin
        next_s.sh1 = s.cmp1;
      end
      if (!s.lock2) begin
        next_s.sh2 = s.cmp2;
      end
    end

    // counting and compare, always compared against the shadows
    if (tick) begin
      next_s.cnt = s.cnt + 16'h0001;
      unique case (mode)
        TMR_MODE_PWM: begin
          // compare active regardless of pin enables
          if (s.cnt == s.sh2) begin
            next_s.cnt = `TMR_RELOAD;
            next_s.out1 = level_after_match_two;
            next_s.cf1 = 1'b1;
            // new values only at period end, to avoid output spikes
            if (!s.lock1) begin
              next_s.sh1 = s.cmp1;
            end
            if (!s.lock2) begin
              next_s.sh2 = s.cmp2;
            end
          end else if (s.cnt == s.sh1) begin
            next_s.out1 = level_after_match_one;
          end
          // no compare flags in pwm mode
        end
        TMR_MODE_ONE: begin
          if (s.cnt == s.sh1) begin
            next_s.out1 = level_after_match_one;
          end
          // compare flag one stays clear; flag two still counts time
          if (s.cnt == s.sh2) begin
            next_s.mf2 = 1'b1;
          end
        end
        TMR_MODE_CMP: begin
          if (s.cnt == s.sh1) begin
            next_s.out1 = level_after_match_one;
            next_s.mf1 = 1'b1;
          end
          if (s.cnt == s.sh2) begin
            next_s.out2 = level_after_match_two;
            next_s.mf2 = 1'b1;
          end
        end
      endcase
    end

    // input one: trigger in single shot, capture in plain mode, unused in pwm
    if (edge_one) begin
      unique case (mode)
        TMR_MODE_ONE: begin
          next_s.cap1 = s.cnt;
          next_s.cnt = `TMR_RELOAD;
          next_s.out1 = level_after_match_two;
          next_s.cf1 = 1'b1;
        end
        TMR_MODE_CMP: begin
          next_s.cap1 = s.cnt;
          next_s.cf1 = 1'b1;
        end
        TMR_MODE_PWM: begin
          // the pin is ignored while the period runs
        end
      endcase
    end

    // input two captures in every mode
    if (edge_two) begin
      next_s.cap2 = s.cnt;
      next_s.cf2 = 1'b1;
    end

    // equal levels give a steady output in the waveform modes
    if (mode != TMR_MODE_CMP && level_after_match_one == level_after_match_two) begin
      next_s.out1 = level_after_match_one;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.ctrl1 <= `TMR_RST_CTRL1;
      s.ctrl2 <= `TMR_RST_CTRL2;
      s.cnt <= `TMR_RST_CNT;
      s.presc <= 3'h0;
      s.cmp1 <= `TMR_RST_CMP;
      s.cmp2 <= `TMR_RST_CMP;
      s.sh1 <= `TMR_RST_CMP;
      s.sh2 <= `TMR_RST_CMP;
      s.cap1 <= 16'h0000;
      s.cap2 <= 16'h0000;
      s.lock1 <= 1'b0;
      s.lock2 <= 1'b0;
      s.cf1 <= 1'b0;
      s.cf2 <= 1'b0;
      s.mf1 <= 1'b0;
      s.mf2 <= 1'b0;
      s.arm <= 4'h0;
      s.s_in1 <= 3'h0;
      s.s_in2 <= 3'h0;
      s.s_ext <= 3'h0;
      s.out1 <= 1'b0;
      s.out2 <= 1'b0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt

  // pin enables only route the waveform; compare logic runs regardless
  assign compare_out_pin_one_o = s.out1;
  assign compare_out_pin_one_oe = s.ctrl2[`TMR_C2_OUT1_EN];
  assign compare_out_pin_two_o = s.out2;
  assign compare_out_pin_two_oe = s.ctrl2[`TMR_C2_OUT2_EN];

  // core-side interrupt mask is applied by the processor, not here
  assign capture_request = capture_irq_enable & (s.cf1 | s.cf2);
  assign compare_request = compare_irq_enable & (s.mf1 | s.mf2);
  assign timer_irq = capture_request | compare_request;

endmodule : tmr_pulse_timer

// ---- tb/tmr_pulse_props.sv ----
// port checker for the pulse timer
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_pulse_chk import tmr_pkg::*; #(
  parameter bit HAS_EXT_PIN = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tmr_apb_req_t apb_req,
  input wire tmr_apb_rsp_t apb_rsp,
  // pins
  input wire logic capture_in_pin_one,
  input wire logic compare_out_pin_one_o,
  input wire logic compare_out_pin_one_oe,
  input wire logic compare_out_pin_two_oe,
  input wire logic timer_irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  logic acc;
  logic wr;
  logic quiet;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [1:0] age;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite && apb_req.paddr <= `TMR_OFF_CTRL2;
  // outputs may lag a control write by three cycles
  assign quiet = age == 2'd3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1 <= '0;
      c2 <= '0;
      age <= '0;
    end else begin
      if (wr && apb_req.paddr == `TMR_OFF_CTRL1) begin
        c1 <= apb_req.pwdata[7:0];
      end
      if (wr && apb_req.paddr == `TMR_OFF_CTRL2) begin
        c2 <= apb_req.pwdata[7:0];
      end
      age <= wr ? 2'd0 : (quiet ? age : age + 2'd1);
    end
  end
  ////////////////////////////////////////
  zero_wait_a: assert property (acc |-> apb_rsp.pready)
    else $error("access without ready");
  unmapped_err_a: assert property (acc && apb_req.paddr[1:0] == 2'b00
    |-> apb_rsp.pslverr == (apb_req.paddr > `TMR_OFF_CNT_LO)) else $error("slave error wrong");
  read_upper_a: assert property (acc && !apb_req.pwrite |-> apb_rsp.prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  ctrl_read_a: assert property (acc && !apb_req.pwrite && apb_req.paddr == `TMR_OFF_CTRL2
    |-> apb_rsp.prdata[7:0] == c2) else $error("control two readback wrong");
  pin_one_en_a: assert property (quiet |-> compare_out_pin_one_oe == c2[7])
    else $error("pin one enable wrong");
  pin_two_en_a: assert property (quiet |-> compare_out_pin_two_oe == c2[6])
    else $error("pin two enable wrong");
  irq_off_a: assert property (quiet && c1[7:6] == 2'b00 |-> !timer_irq)
    else $error("irq without enable");
  level_hold_a: assert property (quiet && c2[5:4] != 2'b00 && c1[1] == c1[0]
    |=> $stable(compare_out_pin_one_o) && compare_out_pin_one_o == c1[0]) else $error("level not steady");
  trig_out_a: assert property ($rose(capture_in_pin_one) && quiet && c2[5:4] == 2'b10 && c1[2]
    |-> ##[2:5] compare_out_pin_one_o == c1[1]) else $error("trigger level missing");
  trig_c: cover property ($rose(capture_in_pin_one) && c2[5:4] == 2'b10);
  pwm_c: cover property (c2[4] && $rose(compare_out_pin_one_o));
  err_c: cover property (apb_rsp.pslverr);
endmodule : tmr_pulse_chk

bind tmr_pulse_timer tmr_pulse_chk #(.HAS_EXT_PIN(HAS_EXT_PIN)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .capture_in_pin_one(capture_in_pin_one),
  .compare_out_pin_one_o(compare_out_pin_one_o),
  .compare_out_pin_one_oe(compare_out_pin_one_oe),
  .compare_out_pin_two_oe(compare_out_pin_two_oe),
  .timer_irq(timer_irq)
);

// ---- tb/tmr_pin_partner.sv ----
// far side: trigger and clock pin driver, waveform load timer
`timescale 1ns/1ps
module tmr_pin_partner (
  // clock
  input wire logic pclk,
  // pins into the timer
  output logic trig_one,
  output logic trig_two,
  output logic ext_clk,
  // waveform load
  input wire logic wave_one
);
  initial begin
    trig_one = 1'b0;
    trig_two = 1'b0;
    ext_clk = 1'b0;
  end
  // levels stand four cycles, past the two-stage synchroniser
  task automatic drive(input logic [2:0] lv);
    @(posedge pclk);
    {ext_clk, trig_two, trig_one} <= lv;
    repeat (4) @(posedge pclk);
  endtask : drive
  // bounded, so a dead waveform cannot hang the run
  task automatic span(input logic v, output int c);
    c = 0;
    while (wave_one !== v && c < 5000) begin
      @(posedge pclk);
      c++;
    end
  endtask : span
  task automatic measure(output int hi, output int per);
    int c;
    // the first period may straddle a settings change, so skip it
    span(1'b0, c);
    span(1'b1, c);
    span(1'b0, c);
    span(1'b1, c);
    span(1'b0, hi);
    span(1'b1, c);
    per = hi + c;
  endtask : measure
  // rising trigger, then time the low pulse
  task automatic fire(output int w);
    int c;
    @(posedge pclk);
    trig_one <= 1'b1;
    span(1'b0, c);
    span(1'b1, w);
  endtask : fire
endmodule : tmr_pin_partner

// ---- tb/testbench.sv ----
// self-checking bench: registers, external clock, pwm, single shot, capture two
`timescale 1ns/1ps
`include "tmr_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module testbench import tmr_pkg::*; ;
  logic pclk;
  logic presetn;
  tmr_apb_req_t req;
  tmr_apb_rsp_t rsp;
  logic pin1, pin2, ext, o1, o2, oe1, oe2, irq, err;
  logic [31:0] rd;
  int num_errors;
  int num_checks;
  tmr_pulse_timer #(.HAS_EXT_PIN(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .capture_in_pin_one(pin1), .capture_in_pin_two(pin2), .ext_timer_clock_pin(ext),
    .compare_out_pin_one_o(o1), .compare_out_pin_one_oe(oe1), .compare_out_pin_two_o(o2),
    .compare_out_pin_two_oe(oe2), .timer_irq(irq));
  tmr_pin_partner u_far (.pclk(pclk), .trig_one(pin1), .trig_two(pin2), .ext_clk(ext), .wave_one(o1));
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: 32'(d)};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, v[15:8]);
    apb(1'b1, a + 8'h04, v[7:0]);
  endtask : wr16
  task automatic t_regs();
    apb(1'b0, `TMR_OFF_CTRL2, 8'h00);
    `CHK("ctrl2 reset", 8'h00, rd[7:0])
    apb(1'b1, `TMR_OFF_CTRL2, 8'hA5);
    apb(1'b0, `TMR_OFF_CTRL2, 8'h00);
    `CHK("ctrl2 readback", 8'hA5, rd[7:0])
    `CHK("pin one on", 1'b1, oe1)
    `CHK("pin two off", 1'b0, oe2)
    apb(1'b1, `TMR_OFF_CTRL2, 8'h40);
    apb(1'b0, 8'h3C, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    `CHK("pin one off", 1'b0, oe1)
    `CHK("pin two on", 1'b1, oe2)
    $display("regs done");
  endtask : t_regs
  task automatic t_ext();
    logic [7:0] base;
    logic sel;
    for (int i = 0; i < 4; i++) begin
      sel = i < 2;
      apb(1'b1, `TMR_OFF_CTRL2, 8'h0C | {7'h00, sel});
      apb(1'b0, `TMR_OFF_CNT_LO, 8'h00);
      base = rd[7:0];
      u_far.drive({~i[0], 2'h0});
      apb(1'b0, `TMR_OFF_CNT_LO, 8'h00);
      `CHK("ext count", 8'(base + (sel == ~i[0])), rd[7:0])
    end
    $display("ext done");
  endtask : t_ext
  task automatic t_pwm();
    int hi, per;
    int dv[3] = '{4, 2, 8};
    // park the counter at the reload value so short periods are reached at once
    apb(1'b1, `TMR_OFF_CTRL2, 8'h2C);
    u_far.drive(3'h1);
    u_far.drive(3'h0);
    wr16(`TMR_OFF_CMP1_HI, 16'h0003);
    wr16(`TMR_OFF_CMP2_HI, 16'h0009);
    apb(1'b1, `TMR_OFF_CTRL1, 8'h02);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `TMR_OFF_CTRL2, 8'h90 | 8'(k << 2) | (k == 1 ? 8'h20 : 8'h00));
      u_far.measure(hi, per);
      `CHK("pwm period", 14 * dv[k], per)
      `CHK("pwm pulse", 8 * dv[k], hi)
    end
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("pwm flags", 3'h4, {rd[7], rd[6], rd[3]})
    apb(1'b1, `TMR_OFF_CMP2_HI, 8'h01);
    u_far.measure(hi, per);
    `CHK("locked period", 14 * 8, per)
    wr16(`TMR_OFF_CMP2_HI, 16'h000E);
    u_far.measure(hi, per);
    `CHK("new period", 19 * 8, per)
    apb(1'b1, `TMR_OFF_CTRL1, 8'h03);
    repeat (3) @(posedge pclk);
    u_far.span(1'b0, hi);
    `CHK("steady level", 5000, hi)
    $display("pwm done");
  endtask : t_pwm
  task automatic t_one();
    int w;
    apb(1'b1, `TMR_OFF_CTRL2, 8'hA0);
    wr16(`TMR_OFF_CMP1_HI, 16'h0006);
    apb(1'b1, `TMR_OFF_CTRL1, 8'h85);
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    apb(1'b0, `TMR_OFF_CAP1_LO, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    u_far.fire(w);
    `CHK("pulse width", 1'b1, w inside {[11 * 4 - 3 : 11 * 4]})
    `CHK("irq on trigger", 1'b1, irq)
    apb(1'b0, `TMR_OFF_CAP1_LO, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("flag kept", 1'b1, irq)
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("one shot flags", 2'h2, {rd[7], rd[6]})
    apb(1'b0, `TMR_OFF_CAP1_LO, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("flag cleared", 1'b0, irq)
    u_far.drive(3'h0);
    $display("one shot done");
  endtask : t_one
  task automatic t_cap2();
    logic [15:0] now;
    // external clock without edges freezes the counter
    apb(1'b1, `TMR_OFF_CTRL2, 8'h4E);
    apb(1'b1, `TMR_OFF_CTRL1, 8'h02);
    apb(1'b0, `TMR_OFF_CNT_HI, 8'h00);
    now[15:8] = rd[7:0];
    apb(1'b0, `TMR_OFF_CNT_LO, 8'h00);
    now[7:0] = rd[7:0];
    u_far.drive(3'h2);
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("capture two flag", 1'b1, rd[4])
    apb(1'b0, `TMR_OFF_CAP2_LO, 8'h00);
    `CHK("capture two value", now[7:0], rd[7:0])
    u_far.drive(3'h0);
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("capture two edge", 1'b0, rd[4])
    wr16(`TMR_OFF_CMP2_HI, now);
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("compare two clear", 1'b0, rd[3])
    `CHK("out two idle", 1'b0, o2)
    apb(1'b1, `TMR_OFF_CTRL2, 8'h4F);
    u_far.drive(3'h4);
    `CHK("out two level", 1'b1, o2)
    `CHK("out two routed", 1'b1, oe2)
    apb(1'b0, `TMR_OFF_STATUS, 8'h00);
    `CHK("compare two flag", 1'b1, rd[3])
    u_far.drive(3'h0);
    $display("capture two done");
  endtask : t_cap2
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #1_000_000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    num_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    req = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ext();
    t_pwm();
    t_one();
    t_cap2();
    report_and_stop();
  end
endmodule : testbench
